// [meas_regs_pkg.sv]
// constants for the backup measurement result register slice
// assumes a byte-wide register port on the system clock
package meas_regs_pkg;
    localparam logic [7:0] ADDR_TIME_HIGH   = 8'h07;
    localparam logic [7:0] ADDR_TIME_LOW    = 8'h08;
    localparam logic [7:0] ADDR_CURRENT_ESR = 8'h09;
    localparam logic [7:0] ADDR_RAIL        = 8'h0A;
    localparam logic [7:0] ADDR_OV_LIMIT    = 8'h0B;
    localparam logic [7:0] ADDR_SOURCE      = 8'h0C;
    localparam logic [7:0] ADDR_STORAGE     = 8'h0D;
    localparam logic [4:0] OV_LIMIT_RESET   = 5'h1D;
    localparam int         OV_CODE_W        = 5;
    localparam int         CURRENT_W        = 6;
    localparam int         CURRENT_LSB      = 2;
    localparam int         ESR_BIT          = 0;
    localparam int         TIMER_W          = 16;
    localparam int         STEP_W           = 8;
    localparam logic [1:0] ESR_SEL_RESET    = 2'h0;
endpackage

// [meas_capture_if.sv]
// result write and read ports carried between the top and its result store
// assumes one system clock
`timescale 1ns/1ps
interface meas_capture_if;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport ctrl  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// [meas_result_store.sv]
// small store of the read-only result bytes, registered read data
// assumes the writer and reader share clk
`timescale 1ns/1ps
module meas_result_store #(
    parameter int DEPTH = 7
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    meas_capture_if.store      port
);
    logic [7:0] mem_reg [DEPTH];

    initial begin
        if (DEPTH < 1 || DEPTH > 8) $error("result store depth out of range");
    end

    // results clear to zero at reset, then take each capture
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) mem_reg[i] <= 8'h00;
            port.rd_data <= 8'h00;
        end else begin
            if (port.wr_en && 32'(port.wr_idx) < DEPTH) mem_reg[port.wr_idx] <= port.wr_data;
            port.rd_data <= (32'(port.rd_idx) < DEPTH) ? mem_reg[port.rd_idx] : 8'h00;
        end
    end
endmodule

// [backup_measurement_result_regs.sv]
// register slice holding timer, current/esr, voltage results and storage limit
// assumes results arrive from converter logic on clk; host port is byte wide
`timescale 1ns/1ps
module backup_measurement_result_regs #(
    parameter int STEP_W = meas_regs_pkg::STEP_W
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              adc_done,
    input  wire logic [7:0]        rail_code,
    input  wire logic [7:0]        source_code,
    input  wire logic [7:0]        storage_code,
    input  wire logic [5:0]        current_code,
    input  wire logic              meas_done,
    input  wire logic [15:0]       discharge_ticks,
    input  wire logic [1:0]        esr_threshold_select,
    input  wire logic [STEP_W-1:0] storage_step,
    input  wire logic [STEP_W-1:0] esr_level_50,
    input  wire logic [STEP_W-1:0] esr_level_100,
    input  wire logic [STEP_W-1:0] esr_level_150,
    input  wire logic [STEP_W-1:0] esr_level_200,
    output logic [4:0]             storage_overvoltage_limit
);
    typedef enum {CAP_IDLE, CAP_RAIL, CAP_SOURCE, CAP_STORAGE, CAP_CURRENT} cap_state_t;

    initial begin
        if (STEP_W < 1 || STEP_W > 16) $error("step width out of range");
    end

    meas_capture_if cap ();

    meas_result_store #(.DEPTH(7)) store_u (
        .clk     (clk),
        .sys_rst (sys_rst),
        .port    (cap)
    );

    // map register offset to store slot; 7 means not in store
    function automatic logic [2:0] slot_of(input logic [7:0] a);
        case (a)
            meas_regs_pkg::ADDR_TIME_HIGH:   slot_of = 3'h0;
            meas_regs_pkg::ADDR_TIME_LOW:    slot_of = 3'h1;
            meas_regs_pkg::ADDR_CURRENT_ESR: slot_of = 3'h2;
            meas_regs_pkg::ADDR_RAIL:        slot_of = 3'h3;
            meas_regs_pkg::ADDR_SOURCE:      slot_of = 3'h4;
            meas_regs_pkg::ADDR_STORAGE:     slot_of = 3'h5;
            default:                         slot_of = 3'h7;
        endcase
    endfunction

    cap_state_t  state_reg;
    cap_state_t  state_next;
    logic [4:0]  limit_reg;
    logic        esr_err_reg;
    logic [1:0]  time_pend_reg;
    logic [7:0]  rail_hold_reg;
    logic [7:0]  source_hold_reg;
    logic [7:0]  storage_hold_reg;
    logic [5:0]  current_hold_reg;
    logic [15:0] ticks_hold_reg;
    logic        rd_pend_reg;
    logic        rd_limit_reg;

    // esr threshold selection and compare
    wire [STEP_W-1:0] esr_level = (esr_threshold_select == 2'h0) ? esr_level_50 :
                                  (esr_threshold_select == 2'h1) ? esr_level_100 :
                                  (esr_threshold_select == 2'h2) ? esr_level_150 : esr_level_200;
    wire esr_error_now = storage_step > esr_level;
    wire limit_hit     = reg_wr && reg_addr == meas_regs_pkg::ADDR_OV_LIMIT;
    wire [2:0] rd_slot = slot_of(reg_addr);

    // timer bytes are weighted 2ms per lsb low, 512ms per lsb high
    wire [7:0] time_low  = ticks_hold_reg[7:0];
    wire [7:0] time_high = ticks_hold_reg[15:8];
    // current code in 7..2, bit 1 reserved zero, bit 0 esr status
    wire [7:0] current_byte = {current_hold_reg, 1'b0, esr_err_reg};

    // capture sequencer writes one result per cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CAP_IDLE:    if (adc_done) state_next = CAP_RAIL;
            CAP_RAIL:    state_next = CAP_SOURCE;
            CAP_SOURCE:  state_next = CAP_STORAGE;
            CAP_STORAGE: state_next = CAP_CURRENT;
            CAP_CURRENT: state_next = CAP_IDLE;
            default:     state_next = CAP_IDLE;
        endcase
    end

    // store write port: timer bytes take priority once a measurement finishes
    assign cap.wr_en   = (time_pend_reg != 2'h0) || (state_reg != CAP_IDLE);
    assign cap.wr_idx  = time_pend_reg[1] ? 3'h0 : time_pend_reg[0] ? 3'h1 :
                         (state_reg == CAP_RAIL) ? 3'h3 : (state_reg == CAP_SOURCE) ? 3'h4 :
                         (state_reg == CAP_STORAGE) ? 3'h5 : 3'h2;
    assign cap.wr_data = time_pend_reg[1] ? time_high : time_pend_reg[0] ? time_low :
                         (state_reg == CAP_RAIL) ? rail_hold_reg :
                         (state_reg == CAP_SOURCE) ? source_hold_reg :
                         (state_reg == CAP_STORAGE) ? storage_hold_reg : current_byte;
    assign cap.rd_idx  = rd_slot;
    assign storage_overvoltage_limit = limit_reg;

    // sequencer and held snapshots
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg        <= CAP_IDLE;
            rail_hold_reg    <= 8'h00;
            source_hold_reg  <= 8'h00;
            storage_hold_reg <= 8'h00;
            current_hold_reg <= 6'h00;
            esr_err_reg      <= 1'b0;
        end else begin
            // a new walk may start while timer bytes pend; it pauses past idle instead
            state_reg <= (time_pend_reg != 2'h0 && state_reg != CAP_IDLE) ? state_reg : state_next;
            if (state_reg == CAP_IDLE && adc_done) begin
                rail_hold_reg    <= rail_code;
                source_hold_reg  <= source_code;
                storage_hold_reg <= storage_code;
                current_hold_reg <= current_code;
                esr_err_reg      <= esr_error_now;
            end
        end
    end

    // timer snapshot and its two pending writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ticks_hold_reg <= 16'h0000;
            time_pend_reg  <= 2'h0;
        end else if (meas_done) begin
            ticks_hold_reg <= discharge_ticks;
            time_pend_reg  <= 2'h3;
        end else if (time_pend_reg[1]) begin
            time_pend_reg  <= 2'h1;
        end else begin
            time_pend_reg  <= 2'h0;
        end
    end

    // limit register, only bits 4..0 writable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            limit_reg <= meas_regs_pkg::OV_LIMIT_RESET;
        end else if (limit_hit) begin
            limit_reg <= reg_wdata[4:0];
        end
    end

    // read pipeline matched to the store's registered data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_reg  <= 1'b0;
            rd_limit_reg <= 1'b0;
        end else begin
            rd_pend_reg  <= reg_rd;
            rd_limit_reg <= reg_addr == meas_regs_pkg::ADDR_OV_LIMIT;
        end
    end

    // read data: limit with reserved zeros, else store, unmapped reads zero
    assign reg_rdata  = rd_limit_reg ? {3'h0, limit_reg} : cap.rd_data;
    assign reg_rvalid = rd_pend_reg;

    // guards on the limit register, the capture walk and the read answer
    limit_reset_a: assert property (@(posedge clk) $fell(sys_rst) |-> limit_reg == meas_regs_pkg::OV_LIMIT_RESET)
        else $error("limit not at reset value");
    limit_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        limit_hit |=> limit_reg == $past(reg_wdata[4:0]))
        else $error("limit write lost");
    limit_rsvd_a: assert property (@(posedge clk) disable iff (sys_rst)
        rd_limit_reg |-> reg_rdata[7:5] == 3'h0)
        else $error("limit reserved bits nonzero");
    sequence adc_walk_s;
        state_reg == CAP_IDLE && adc_done && time_pend_reg == 2'h0;
    endsequence
    rail_write_a: assert property (@(posedge clk) disable iff (sys_rst || meas_done)
        adc_walk_s |=> cap.wr_en && cap.wr_idx == 3'h3 && cap.wr_data == $past(rail_code))
        else $error("rail result not written");
    source_write_a: assert property (@(posedge clk) disable iff (sys_rst || meas_done)
        adc_walk_s ##1 time_pend_reg == 2'h0 |=> cap.wr_idx == 3'h4 && cap.wr_data == $past(source_code, 2))
        else $error("source result not written");
    storage_write_a: assert property (@(posedge clk) disable iff (sys_rst || meas_done)
        adc_walk_s ##1 time_pend_reg == 2'h0 [*2]
        |=> cap.wr_idx == 3'h5 && cap.wr_data == $past(storage_code, 3))
        else $error("storage result wrong");
    current_byte_a: assert property (@(posedge clk) disable iff (sys_rst || meas_done)
        adc_walk_s ##1 time_pend_reg == 2'h0 [*3]
        |=> cap.wr_idx == 3'h2 && cap.wr_data[7:2] == $past(current_code, 4) && cap.wr_data[1] == 1'b0)
        else $error("current byte malformed");
    esr_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        adc_walk_s |=> esr_err_reg == $past(esr_error_now))
        else $error("esr status not captured");
    // timer bytes land high first, then low, from one snapshot
    timer_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
        meas_done |=> cap.wr_en && cap.wr_idx == 3'h0 && cap.wr_data == $past(discharge_ticks[15:8]))
        else $error("timer high byte not written");
    timer_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        meas_done ##1 !meas_done
        |=> cap.wr_en && cap.wr_idx == 3'h1 && cap.wr_data == $past(discharge_ticks[7:0], 2))
        else $error("timer low byte not written");
    read_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");
endmodule

// [meas_source.sv]
// converter-side model: result codes and completion pulses
// assumes the slice samples codes on adc_done and ticks on meas_done
`timescale 1ns/1ps
module meas_source (
    input  wire logic  clk,
    output logic       adc_done,
    output logic [7:0] rail_code,
    output logic [7:0] source_code,
    output logic [7:0] storage_code,
    output logic [5:0] current_code,
    output logic [7:0] storage_step,
    output logic       meas_done,
    output logic [15:0] discharge_ticks
);
    // idle values at time zero
    initial begin
        adc_done = 1'b0;
        meas_done = 1'b0;
        {rail_code, source_code, storage_code, current_code, storage_step} = '0;
        discharge_ticks = 16'h0000;
    end

    // one conversion pulse; codes go stale (inverted) right after
    task automatic convert(input logic [7:0] r, s, t, input logic [5:0] c, input logic [7:0] st);
        @(posedge clk);
        adc_done <= 1'b1;
        {rail_code, source_code, storage_code, current_code, storage_step} <= {r, s, t, c, st};
        @(posedge clk);
        adc_done <= 1'b0;
        {rail_code, source_code, storage_code, current_code, storage_step} <= ~{r, s, t, c, st};
    endtask

    // one discharge timer snapshot
    task automatic stamp(input logic [15:0] ticks);
        @(posedge clk);
        meas_done <= 1'b1;
        discharge_ticks <= ticks;
        @(posedge clk);
        meas_done <= 1'b0;
        discharge_ticks <= ~ticks;
    endtask
endmodule

// [backup_measurement_result_regs_tb_top.sv]
// self-checking bench for the measurement result slice
// assumes meas_source drives the converter side; bench drives the register port
`timescale 1ns/1ps
module backup_measurement_result_regs_tb_top;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic [1:0]  esr_threshold_select = 2'h0;
    logic [7:0]  reg_rdata, rail_code, source_code, storage_code, storage_step;
    logic        reg_rvalid, adc_done, meas_done;
    logic [5:0]  current_code;
    logic [15:0] discharge_ticks;
    logic [4:0]  storage_overvoltage_limit;
    logic [7:0]  level_tab [4] = '{8'h0A, 8'h14, 8'h1E, 8'h28};
    int          mismatches = 0;
    int          checks_done = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    backup_measurement_result_regs backup_measurement_result_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_done(adc_done),
        .rail_code(rail_code), .source_code(source_code), .storage_code(storage_code),
        .current_code(current_code), .meas_done(meas_done), .discharge_ticks(discharge_ticks),
        .esr_threshold_select(esr_threshold_select), .storage_step(storage_step),
        .esr_level_50(level_tab[0]), .esr_level_100(level_tab[1]), .esr_level_150(level_tab[2]),
        .esr_level_200(level_tab[3]), .storage_overvoltage_limit(storage_overvoltage_limit));

    meas_source meas_source_inst (
        .clk(clk), .adc_done(adc_done), .rail_code(rail_code), .source_code(source_code),
        .storage_code(storage_code), .current_code(current_code), .storage_step(storage_step),
        .meas_done(meas_done), .discharge_ticks(discharge_ticks));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, answer one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
        @(posedge clk);
        #1;
        check({7'h00, reg_rvalid}, 8'h00);
    endtask

    // hold reset for 20 cycles
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // every register at its power-on value, unmapped reads zero
    task automatic reset_values;
        for (int a = 7; a <= 13; a++)
            rd(8'(a), (a == 11) ? 8'h1D : 8'h00);
        rd(8'h20, 8'h00);
        check({3'h0, storage_overvoltage_limit}, 8'h1D);
        $display("test reset values done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset;
        reset_values;
        wr(8'h08, 8'hFF);
        wr(8'h0A, 8'hFF);
        wr(8'h0D, 8'hFF);
        rd(8'h08, 8'h00);
        rd(8'h0A, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h0B, 8'h1D);
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'h1F);
        check({3'h0, storage_overvoltage_limit}, 8'h1F);
        wr(8'h0B, 8'h00);
        rd(8'h0B, 8'h00);
        $display("test write access done");
        meas_source_inst.convert(8'hA5, 8'h5A, 8'hC3, 6'h2B, 8'h00);
        repeat (6) @(posedge clk);
        rd(8'h0A, 8'hA5);
        rd(8'h0C, 8'h5A);
        rd(8'h0D, 8'hC3);
        rd(8'h09, 8'hAC);
        $display("test conversion done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            esr_threshold_select <= 2'(s);
            for (int k = 0; k < 2; k++) begin
                meas_source_inst.convert(8'h01, 8'h02, 8'h03, 6'h3F, level_tab[s] + 8'(k));
                repeat (6) @(posedge clk);
                rd(8'h09, {6'h3F, 1'b0, 1'(k)});
            end
        end
        $display("test esr select done");
        meas_source_inst.stamp(16'hBEEF);
        repeat (4) @(posedge clk);
        rd(8'h07, 8'hBE);
        rd(8'h08, 8'hEF);
        meas_source_inst.stamp(16'hFFFF);
        repeat (4) @(posedge clk);
        rd(8'h07, 8'hFF);
        rd(8'h08, 8'hFF);
        $display("test timer done");
        wr(8'h0B, 8'h03);
        do_reset;
        reset_values;
        summarize;
    end
endmodule
